// File: hw/rsl_pkg.sv
// rsl_pkg: constants, register map and carrier types for the reset,
// strap and port-0 link/activity indicator block.
// assumes a single 100 MHz clock and a 32-bit APB register bus.
package rsl_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_IRQ_CFG = 12'h000;
    localparam logic [11:0] ADDR_STRAP = 12'h004;
    localparam logic [11:0] ADDR_RST_CTRL = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;

    // interrupt configuration fields
    localparam int IRQ_POL_BIT = 0; // 1 = active high
    localparam int IRQ_OD_BIT = 1; // 1 = open-drain, 0 = push-pull
    localparam int IRQ_SRC_LSB = 4;
    localparam int IRQ_SRC_W = 2;
    localparam logic [31:0] IRQ_CFG_RST = 32'h00000000;

    // interrupt source selection codes
    localparam logic [1:0] SRC_EVENT = 2'h0; // core event input
    localparam logic [1:0] SRC_LINK = 2'h1; // port-0 link up
    localparam logic [1:0] SRC_ACT = 2'h2; // port-0 activity
    localparam logic [1:0] SRC_NONE = 2'h3; // never asserted

    // strap register fields
    localparam int STRAP_MODE_LSB = 0;
    localparam int STRAP_LED_BIT = 4;
    localparam int STRAP_DONE_BIT = 8;

    // reset control: writing this bit starts a commanded reset
    localparam int RST_CMD_BIT = 0;

    // ----------------------------------------------------------------
    // timing constants
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int POR_US = 100; // internal power-on reset length
    localparam int POR_CYC = POR_US * CLK_MHZ;
    localparam int CMD_RST_US = 10; // commanded reset pulse length
    localparam int CMD_RST_CYC = CMD_RST_US * CLK_MHZ;
    localparam int BLINK_MS = 50; // led toggle half-period
    localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 24;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POR = 3'b001,
        ST_RUN = 3'b010,
        ST_CMDRST = 3'b100
    } rsl_state_t;

    // latched configuration straps
    typedef struct packed {
        logic [1:0] chipMode;
        logic ledStrap;
        logic valid;
    } rsl_strap_t;

    // two-signal pin carrier
    typedef struct packed {
        logic out;
        logic oe;
    } rsl_pin_t;

endpackage

// File: hw/rsl_reset_strap_led.sv
// rsl_reset_strap_led: power-on and commanded reset sequencing, strap
// capture, port-0 link/activity led drive and irq output shaping.
// assumes strap and pin inputs synchronous to clk; the bench resolves
// the two-way pins from the out/oe pairs.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ns

// Contract
// - led off, on with link, blinking with traffic
// - led drive type and polarity from strap
// - latch straps at reset release, hold after
// - chip mode from two strap bits
// - software sets irq polarity, source, drive type
// - low reset pin level requests reset
// - internal power-on reset, pin may float high
// - drive reset pin low during por, command reset
module rsl_reset_strap_led #(
    parameter int POR_CYCLES = rsl_pkg::POR_CYC, // power-on reset length
    parameter int CMD_CYCLES = rsl_pkg::CMD_RST_CYC, // command reset
    parameter int BLINK_CYCLES = rsl_pkg::BLINK_CYC // led half period
) (
    input wire logic clk, // 100 MHz system clock
    input wire logic nrst, // async active-low power-on reset
    input wire logic rstPinIn, // level seen on the reset pin
    output logic rstPinOut, // reset pin drive value (always low)
    output logic rstPinOe, // high while pulling reset pin low
    output logic sysRst_n, // active-low reset to the rest of chip
    input wire logic hostRstReq, // one-cycle reset command from master
    input wire logic chip_cfg_strap_bit0, // chip mode strap bit 0
    input wire logic chip_cfg_strap_bit1, // chip mode strap bit 1
    input wire logic ledPinIn, // strap level on the led pin
    output logic port0_link_activity_led, // led pin drive value
    output logic ledOe, // led pin output enable
    input wire logic linkUp, // port-0 link present
    input wire logic activity, // port-0 traffic pulse or level
    input wire logic irqEvent, // core interrupt event level
    output logic irqOut, // irq pin drive value
    output logic irqOe, // irq pin output enable
    output logic [1:0] chipMode, // latched chip mode hard-strap
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr // apb error on unmapped address
);
    import rsl_pkg::*;

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------
    rsl_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] rstCnt_ff, nxt_rstCnt;
    rsl_strap_t strap_ff, nxt_strap;
    logic rstOe_ff, nxt_rstOe;
    logic sysRst_ff, nxt_sysRst;
    logic cmdWr;

    // the pin is read only while we are not driving it, else our own
    // pull-down would look like an external request and never release
    always_comb begin
        nxt_state = state_ff;
        nxt_rstCnt = rstCnt_ff;
        nxt_strap = strap_ff;
        case (state_ff)
            ST_POR: begin
                if (rstCnt_ff == CNT_W'(POR_CYCLES - 1)) begin
                    nxt_state = ST_RUN;
                    nxt_rstCnt = '0;
                end else begin
                    nxt_rstCnt = rstCnt_ff + 1'b1;
                end
            end
            ST_RUN: begin
                if (hostRstReq || cmdWr) begin
                    nxt_state = ST_CMDRST;
                    nxt_rstCnt = '0;
                end
            end
            ST_CMDRST: begin
                if (rstCnt_ff == CNT_W'(CMD_CYCLES - 1)) begin
                    nxt_state = ST_RUN;
                    nxt_rstCnt = '0;
                end else begin
                    nxt_rstCnt = rstCnt_ff + 1'b1;
                end
            end
            default: begin
                nxt_state = ST_POR;
                nxt_rstCnt = '0;
            end
        endcase
        // external hold: a low pin keeps the chip in reset
        if (!rstOe_ff && !rstPinIn) begin
            nxt_state = ST_RUN;
            nxt_rstCnt = '0;
        end
        // pin drive and internal reset follow the next state directly,
        // kept in this process so strap capture sees no feedback loop
        nxt_rstOe = (nxt_state != ST_RUN);
        nxt_sysRst = (nxt_state == ST_RUN) &&
                     (rstOe_ff || rstPinIn);
        // capture straps on the first cycle out of any reset
        if (nxt_sysRst && !sysRst_ff) begin
            nxt_strap.chipMode = {chip_cfg_strap_bit1,
                                  chip_cfg_strap_bit0};
            nxt_strap.ledStrap = ledPinIn;
            nxt_strap.valid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_POR;
            rstCnt_ff <= '0;
            strap_ff <= '0;
            rstOe_ff <= 1'b1;
            sysRst_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            rstCnt_ff <= nxt_rstCnt;
            strap_ff <= nxt_strap;
            rstOe_ff <= nxt_rstOe;
            sysRst_ff <= nxt_sysRst;
        end
    end

    // ----------------------------------------------------------------
    // link / activity led
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] blinkCnt_ff, nxt_blinkCnt;
    logic blink_ff, nxt_blink;
    logic actSeen_ff, nxt_actSeen;
    logic ledOut_ff, nxt_ledOut;
    logic ledOe_ff, nxt_ledOe;
    logic ledOn;

    // activity is stretched to the end of its blink phase, so a short frame
    // gives a visible blink only if the previous phase also saw activity
    always_comb begin
        nxt_blinkCnt = blinkCnt_ff + 1'b1;
        nxt_blink = blink_ff;
        nxt_actSeen = actSeen_ff | activity;
        if (blinkCnt_ff == CNT_W'(BLINK_CYCLES - 1)) begin
            nxt_blinkCnt = '0;
            nxt_blink = actSeen_ff ? ~blink_ff : 1'b0;
            nxt_actSeen = activity;
        end
        ledOn = linkUp && !(actSeen_ff && blink_ff);
        // strap low: active-high open-source; strap high: active-low
        // open-drain. the pin is only driven toward its active level.
        nxt_ledOut = ~strap_ff.ledStrap;
        nxt_ledOe = sysRst_ff && strap_ff.valid && ledOn;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blinkCnt_ff <= '0;
            blink_ff <= 1'b0;
            actSeen_ff <= 1'b0;
            ledOut_ff <= 1'b0;
            ledOe_ff <= 1'b0;
        end else begin
            blinkCnt_ff <= nxt_blinkCnt;
            blink_ff <= nxt_blink;
            actSeen_ff <= nxt_actSeen;
            ledOut_ff <= nxt_ledOut;
            ledOe_ff <= nxt_ledOe;
        end
    end

    // ----------------------------------------------------------------
    // apb slave and irq shaping
    // ----------------------------------------------------------------
    logic [31:0] irqCfg_ff, nxt_irqCfg;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic irqOut_ff, nxt_irqOut;
    logic irqOe_ff, nxt_irqOe;
    logic setup, irqAct;
    logic mapped;

    // zero-wait answer: pready rises in the access cycle itself
    always_comb begin
        setup = psel && !penable;
        mapped = (paddr == ADDR_IRQ_CFG) || (paddr == ADDR_STRAP) ||
                 (paddr == ADDR_RST_CTRL) || (paddr == ADDR_STATUS);
        cmdWr = psel && penable && pready_ff && pwrite &&
                (paddr == ADDR_RST_CTRL) && pwdata[RST_CMD_BIT];
        nxt_pready = setup;
        nxt_pslverr = setup && !mapped;
        nxt_prdata = '0;
        nxt_irqCfg = irqCfg_ff;
        // source select first: the status read below uses it
        case (irqCfg_ff[IRQ_SRC_LSB +: IRQ_SRC_W])
            SRC_EVENT: irqAct = irqEvent;
            SRC_LINK: irqAct = linkUp;
            SRC_ACT: irqAct = activity;
            default: irqAct = 1'b0;
        endcase
        if (setup && !pwrite) begin
            case (paddr)
                ADDR_IRQ_CFG: nxt_prdata = irqCfg_ff;
                ADDR_STRAP: begin
                    nxt_prdata[STRAP_MODE_LSB +: 2] = strap_ff.chipMode;
                    nxt_prdata[STRAP_LED_BIT] = strap_ff.ledStrap;
                    nxt_prdata[STRAP_DONE_BIT] = strap_ff.valid;
                end
                ADDR_STATUS: nxt_prdata = {26'h0000000, irqOut_ff,
                                           irqAct, linkUp, ledOe_ff,
                                           sysRst_ff, rstOe_ff};
                default: nxt_prdata = '0;
            endcase
        end
        if (psel && penable && pready_ff && pwrite &&
            paddr == ADDR_IRQ_CFG) begin
            nxt_irqCfg = pwdata & 32'h00000033;
        end
        // open-drain pulls low whenever asserted, whatever the polarity bit
        if (irqCfg_ff[IRQ_OD_BIT]) begin
            nxt_irqOut = 1'b0;
            nxt_irqOe = irqAct;
        end else begin
            nxt_irqOut = irqAct ~^ irqCfg_ff[IRQ_POL_BIT];
            nxt_irqOe = 1'b1;
        end
        if (!sysRst_ff) begin
            nxt_irqCfg = IRQ_CFG_RST;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqCfg_ff <= IRQ_CFG_RST;
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irqOut_ff <= 1'b0;
            irqOe_ff <= 1'b0;
        end else begin
            irqCfg_ff <= nxt_irqCfg;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            irqOut_ff <= nxt_irqOut;
            irqOe_ff <= nxt_irqOe;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rstPinOut = 1'b0;
    assign rstPinOe = rstOe_ff;
    assign sysRst_n = sysRst_ff;
    assign port0_link_activity_led = ledOut_ff;
    assign ledOe = ledOe_ff;
    assign irqOut = irqOut_ff;
    assign irqOe = irqOe_ff;
    assign chipMode = strap_ff.chipMode;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

endmodule

// File: test/rsl_pin_model.sv
// rsl_pin_model: board side of the reset pin and the led pin.
// assumes out/oe pairs from the device; no clock needed.
`timescale 1ns/1ns
module rsl_pin_model (
    input wire logic rstPinOe, // device pulls reset pin low
    input wire logic extRst_n, // external reset hardware, low = reset
    input wire logic ledOe, // device drives led pin
    input wire logic ledDrv, // led pin drive value
    input wire logic ledStrap, // strap resistor level on led pin
    output logic rstPinIn, // resolved reset pin level
    output logic ledPinIn // resolved led pin level
);
    // ----------------------------------------------------------------
    // pin resolution
    // ----------------------------------------------------------------
    // pull-up holds the reset pin high unless someone pulls it down
    assign rstPinIn = !(rstPinOe || !extRst_n);
    // strap resistor wins only while the led pin is released
    assign ledPinIn = ledOe ? ledDrv : ledStrap;
endmodule

// File: test/rsl_chk.sv
// rsl_chk: timing relations on the reset, strap, led and apb ports.
// assumes binding into rsl_reset_strap_led, single clock domain.
`timescale 1ns/1ns
module rsl_chk #(
    parameter int POR_CYCLES = 8, // power-on reset length
    parameter int CMD_CYCLES = 4 // command reset length
) (
    input wire logic clk, // clock
    input wire logic nrst, // async reset
    input wire logic rstPinIn, // reset pin level
    input wire logic rstPinOe, // reset pin pull-down
    input wire logic sysRst_n, // internal reset
    input wire logic hostRstReq, // reset command
    input wire logic chip_cfg_strap_bit0, // mode strap 0
    input wire logic chip_cfg_strap_bit1, // mode strap 1
    input wire logic port0_link_activity_led, // led drive
    input wire logic ledOe, // led enable
    input wire logic linkUp, // link present
    input wire logic [1:0] chipMode, // latched mode
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic [11:0] paddr, // apb address
    input wire logic pready, // apb ready
    input wire logic pslverr // apb error
);
    // slack on release waits; PORW and CMDW come from params, the [*7] and [*2] low runs are fixed
    localparam int PORW = POR_CYCLES + 4;
    localparam int CMDW = CMD_CYCLES + 2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // ----------------------------------------------------------------
    // reset sequencing
    // ----------------------------------------------------------------
    chk_por_length: assert property ($rose(nrst) |->
        !sysRst_n[*7] ##[0:PORW] sysRst_n) else $error("por length");
    chk_oe_in_reset: assert property (rstPinOe |-> !sysRst_n)
        else $error("pin pulled low outside reset");
    chk_cmd_reset: assert property (
        hostRstReq && sysRst_n && !rstPinOe |=> rstPinOe[*2]
        ##[1:CMDW] !rstPinOe) else $error("command reset pulse");
    chk_ext_reset: assert property (
        !rstPinIn && !rstPinOe |=> !sysRst_n) else $error("ext reset");
    // ----------------------------------------------------------------
    // straps and led
    // ----------------------------------------------------------------
    chk_straps_hold: assert property (
        sysRst_n && $past(sysRst_n) |-> $stable(chipMode))
        else $error("straps moved while running");
    chk_mode_latch: assert property ($rose(sysRst_n) |->
        chipMode == {$past(chip_cfg_strap_bit1),
        $past(chip_cfg_strap_bit0)}) else $error("chip mode not latched");
    chk_led_off: assert property (!linkUp |=> !ledOe)
        else $error("led lit without link");
    chk_led_steady: assert property (
        sysRst_n[*3] |-> $stable(port0_link_activity_led))
        else $error("led drive level moved");
    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    chk_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    chk_apb_error: assert property (
        psel && !penable && paddr > 12'h00C |=> pslverr)
        else $error("no error on unmapped address");
endmodule
bind rsl_reset_strap_led rsl_chk #(.POR_CYCLES(POR_CYCLES),
    .CMD_CYCLES(CMD_CYCLES)) u_chk (.clk(clk), .nrst(nrst),
    .rstPinIn(rstPinIn), .rstPinOe(rstPinOe), .sysRst_n(sysRst_n),
    .hostRstReq(hostRstReq), .chip_cfg_strap_bit0(chip_cfg_strap_bit0),
    .chip_cfg_strap_bit1(chip_cfg_strap_bit1), .ledOe(ledOe),
    .port0_link_activity_led(port0_link_activity_led),
    .linkUp(linkUp), .chipMode(chipMode), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr));

// File: test/tb_rsl_reset_strap_led.sv
// tb_rsl_reset_strap_led: apb and pin driven regression.
// assumes rsl_pin_model resolves the reset and led pins.
`timescale 1ns/1ns
module tb_rsl_reset_strap_led;
    import rsl_pkg::*;
    logic clk = 0, nrst = 0, extRst_n = 1, hostRstReq = 0, bit0 = 0;
    logic bit1 = 1, ledStrap = 1, linkUp = 0, activity = 0, irqEvent = 0;
    logic psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic rstPinIn, rstPinOe, sysRst_n, ledPinIn, ledDrv, ledOe, rstDrv;
    logic irqOut, irqOe, pready, pslverr;
    logic [1:0] chipMode;
    logic [31:0] cfgTab [7] = '{32'h1, 32'h0, 32'h3, 32'h3, 32'h11, 32'h31,
        32'h23};
    logic evTab [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [1:0] expTab [7] = '{2'h3, 2'h2, 2'h2, 2'h0, 2'h3, 2'h2, 2'h0};
    int n_errors = 0, checks_done = 0, cyc = 0, hi = 0, lo = 0;
    // reference clock comes from the bench at the bench rate
    always #5 clk = ~clk;
    rsl_reset_strap_led #(.POR_CYCLES(8), .CMD_CYCLES(4),
        .BLINK_CYCLES(4)) DUT (.clk(clk), .nrst(nrst),
        .rstPinIn(rstPinIn), .rstPinOut(rstDrv), .rstPinOe(rstPinOe),
        .sysRst_n(sysRst_n), .hostRstReq(hostRstReq),
        .chip_cfg_strap_bit0(bit0), .chip_cfg_strap_bit1(bit1),
        .ledPinIn(ledPinIn), .port0_link_activity_led(ledDrv),
        .ledOe(ledOe), .linkUp(linkUp), .activity(activity),
        .irqEvent(irqEvent), .irqOut(irqOut), .irqOe(irqOe),
        .chipMode(chipMode), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rsl_pin_model u_pins (.rstPinOe(rstPinOe), .extRst_n(extRst_n),
        .ledOe(ledOe), .ledDrv(ledDrv), .ledStrap(ledStrap),
        .rstPinIn(rstPinIn), .ledPinIn(ledPinIn));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // request held until pready is sampled high at a rising edge; the
    // answer is taken and the request released at that same edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task waitRun;
        repeat (100) if (sysRst_n !== 1'b1) @(negedge clk);
        repeat (2) @(negedge clk);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // a hang is cut off long after the sequence should have ended
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            wrap_up;
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        waitRun;
        chk(sysRst_n, 1'b1);
        chk(chipMode, 2'b10);
        chk(ledDrv, 1'b0);
        apb(1'b0, ADDR_STRAP, 32'h0);
        chk(rd, 32'h112);
        bit0 <= 1'b1;
        bit1 <= 1'b0;
        ledStrap <= 1'b0;
        apb(1'b0, ADDR_STRAP, 32'h0);
        chk(rd, 32'h112);
        @(negedge clk) chk(ledOe, 1'b0);
        @(posedge clk) linkUp <= 1'b1;
        repeat (3) @(negedge clk);
        chk(ledOe, 1'b1);
        @(posedge clk) activity <= 1'b1;
        repeat (24) @(negedge clk) if (ledOe === 1'b1) hi++; else lo++;
        chk(hi != 0 && lo != 0, 1'b1);
        @(posedge clk) activity <= 1'b0;
        repeat (12) @(negedge clk);
        chk(ledOe, 1'b1);
        // every source code, both polarities and both drive types
        for (int i = 0; i < 7; i++) begin
            @(posedge clk) irqEvent <= evTab[i];
            apb(1'b1, ADDR_IRQ_CFG, cfgTab[i]);
            repeat (2) @(negedge clk);
            chk({irqOe, irqOut}, expTab[i]);
        end
        apb(1'b1, ADDR_IRQ_CFG, 32'hFFFFFFFF);
        apb(1'b0, ADDR_IRQ_CFG, 32'h0);
        chk(rd, 32'h33);
        apb(1'b0, 12'h010, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h00000000);
        @(posedge clk) hostRstReq <= 1'b1;
        @(posedge clk) hostRstReq <= 1'b0;
        @(negedge clk) chk({rstPinOe, rstDrv, sysRst_n}, 3'b100);
        waitRun;
        chk(chipMode, 2'b01);
        apb(1'b1, ADDR_RST_CTRL, 32'h1);
        repeat (2) @(negedge clk);
        chk(rstPinOe, 1'b1);
        waitRun;
        @(posedge clk) extRst_n <= 1'b0;
        bit1 <= 1'b1;
        repeat (2) @(negedge clk);
        chk(sysRst_n, 1'b0);
        @(posedge clk) extRst_n <= 1'b1;
        waitRun;
        chk(chipMode, 2'b11);
        chk(ledDrv, 1'b1);
        // status after the pin reset: irq config is back at reset value,
        // so the event source is active and push-pull active low
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000001E);
        wrap_up;
    end
endmodule
